// ### verilog/pmsw_ctrl.sv
`timescale 1ns/1ns
module pmsw_ctrl #(
  parameter int ADDR_W    = 8,
  parameter int PORT_W    = 8,
  parameter int IRQ_W     = 8,
  parameter int WDT_LIMIT = pmsw_pkg::WDT_LIMIT_DEF
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  halt_req,
  input  wire logic                  watchdog_clear_instruction,
  input  wire logic                  wdt_enable,
  input  wire logic                  stack_full,
  input  wire logic [IRQ_W-1:0]      irq_req,
  input  wire logic [PORT_W-1:0]     port_a_pin,
  input  wire logic                  low_speed_rc_osc_clk_pin,
  input  wire logic                  low_speed_rc_osc_ready_pin,
  input  wire logic                  high_speed_rc_osc_ready_pin,
  output pmsw_pkg::pmsw_osc_t        osc_ctl,
  output pmsw_pkg::pmsw_tick_t       ticks,
  output logic                       cpu_run,
  output logic                       pc_sp_reset,
  output logic                       irq_take,
  output logic                       wdt_reset_req
);

  pmsw_pkg::pmsw_state_t state_q;
  pmsw_pkg::pmsw_sb_t    sb_q;
  pmsw_pkg::pmsw_cause_t cause_q;
  logic [2:0]        sel_q;
  logic              fkeep_q, skeep_q, hen_q, hflag_q, hrun_q;
  logic              pdf_q, to_q;
  logic [PORT_W-1:0] wake_en_q;
  logic [IRQ_W-1:0]  ien_q, armed_q;
  logic              act_slow_q;
  logic [2:0]        act_div_q;
  logic [5:0]        div_q;
  logic [15:0]       wdt_q;
  logic              pc_sp_reset_q, irq_take_q, wdt_reset_q;
  logic [2:0]        lclk_s;
  logic [1:0]        lrdy_s, hrdy_s;
  logic [PORT_W-1:0] pa_s1, pa_s2, pa_s3;
  logic              aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q, rdata_q, rd_word;
  logic [3:0]        w_strb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic              rd_ok, wr_ok, wr_go;
  logic              hs_run, ls_run, hs_stable, ls_stable;
  logic              sub_tick, fast_tick, cur_tick, want_slow;
  logic [5:0]        div_mask;
  logic              pin_wake, irq_wake, wdt_ovf, wake;
  logic [IRQ_W-1:0]  irq_hit;
  logic              in_stby;

  // synchronisers for pins from the analog side
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lclk_s <= 3'h0;
      lrdy_s <= 2'h0;
      hrdy_s <= 2'h0;
      pa_s1  <= '1;
      pa_s2  <= '1;
      pa_s3  <= '1;
    end else begin
      lclk_s <= {lclk_s[1:0], low_speed_rc_osc_clk_pin};
      lrdy_s <= {lrdy_s[0], low_speed_rc_osc_ready_pin};
      hrdy_s <= {hrdy_s[0], high_speed_rc_osc_ready_pin};
      pa_s1  <= port_a_pin;
      pa_s2  <= pa_s1;
      pa_s3  <= pa_s2;
    end
  end

  assign in_stby   = (state_q == pmsw_pkg::ST_STBY);
  assign sub_tick  = lclk_s[1] & ~lclk_s[2];
  assign ls_stable = lrdy_s[1];
  assign hs_stable = hflag_q;
  assign want_slow = (sel_q == pmsw_pkg::SEL_SUB);

  // oscillator run requests per mode
  always_comb begin
    if (state_q == pmsw_pkg::ST_STBY) begin
      hs_run = fkeep_q;
      ls_run = skeep_q | wdt_enable;
    end else if (state_q == pmsw_pkg::ST_WAKE) begin
      hs_run = ~act_slow_q | hen_q | fkeep_q;
      ls_run = 1'b1;
    end else begin
      hs_run = ~act_slow_q | ~want_slow | hen_q;
      ls_run = 1'b1;
    end
  end

  // fast oscillator stable flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrun_q  <= 1'b0;
      hflag_q <= 1'b0;
    end else begin
      hrun_q <= hs_run;
      if (!hs_run || !hrun_q)
        hflag_q <= 1'b0;
      else if (hrdy_s[1])
        hflag_q <= 1'b1;
    end
  end

  // fast divider
  assign div_mask  = 6'((7'h1 << act_div_q) - 7'h1);
  assign fast_tick = hs_stable & ((div_q & div_mask) == div_mask);
  assign cur_tick  = act_slow_q ? sub_tick : fast_tick;

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      div_q <= 6'h0;
    else if (hs_stable)
      div_q <= div_q + 6'h1;
    else
      div_q <= 6'h0;
  end

  // active clock source; changes only right after a tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      act_slow_q <= 1'b0;
      act_div_q  <= pmsw_pkg::SEL_RESET;
    end else if (state_q == pmsw_pkg::ST_RUN) begin
      if (want_slow && !act_slow_q && ls_stable && cur_tick) begin
        act_slow_q <= 1'b1;
      end else if (!want_slow && hs_stable && (cur_tick || act_slow_q)
                   && (act_slow_q ? sub_tick : 1'b1)) begin
        act_slow_q <= 1'b0;
        act_div_q  <= sel_q;
      end
    end
  end

  assign ticks.sys_tick  = cpu_run & cur_tick;
  assign ticks.fast_tick = hs_run & fast_tick;
  assign ticks.sub_tick  = in_stby ? (skeep_q & sub_tick) : sub_tick;
  assign osc_ctl.hs_run  = hs_run;
  assign osc_ctl.ls_run  = ls_run;
  assign cpu_run         = (state_q == pmsw_pkg::ST_RUN);

  // wake sources
  assign pin_wake = |(pa_s3 & ~pa_s2 & wake_en_q);
  assign irq_hit  = irq_req & armed_q;
  assign irq_wake = |irq_hit;
  assign wdt_ovf  = wdt_enable & sub_tick
                    & (wdt_q == 16'(WDT_LIMIT - 1));
  assign wake     = in_stby & (pin_wake | irq_wake | wdt_ovf);

  // watchdog counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      wdt_q <= 16'h0;
    else if ((cpu_run && halt_req) || watchdog_clear_instruction || wdt_ovf)
      wdt_q <= 16'h0;
    else if (wdt_enable && sub_tick)
      wdt_q <= wdt_q + 16'h1;
  end

  // operating state; registers and ports are simply left alone in standby
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= pmsw_pkg::ST_RUN;
      sb_q    <= pmsw_pkg::SB_SLEEP;
      cause_q <= pmsw_pkg::WK_NONE;
      armed_q <= '0;
    end else begin
      case (state_q)
        pmsw_pkg::ST_RUN: begin
          if (halt_req) begin
            state_q <= pmsw_pkg::ST_STBY;
            sb_q    <= pmsw_pkg::pmsw_sb_t'({fkeep_q, skeep_q});
            armed_q <= ~irq_req;
            cause_q <= pmsw_pkg::WK_NONE;
          end
        end
        pmsw_pkg::ST_STBY: begin
          if (wake) begin
            state_q <= pmsw_pkg::ST_WAKE;
            if (wdt_ovf)
              cause_q <= pmsw_pkg::WK_WDT;
            else if (irq_wake)
              cause_q <= pmsw_pkg::WK_IRQ;
            else
              cause_q <= pmsw_pkg::WK_PIN;
          end
        end
        pmsw_pkg::ST_WAKE: begin
          if (act_slow_q ? ls_stable : hs_stable)
            state_q <= pmsw_pkg::ST_RUN;
        end
        default: state_q <= pmsw_pkg::ST_RUN;
      endcase
    end
  end

  // resume actions, one pulse as execution restarts; watchdog reset request on overflow while running
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pc_sp_reset_q <= 1'b0;
      irq_take_q    <= 1'b0;
      wdt_reset_q   <= 1'b0;
    end else begin
      pc_sp_reset_q <= 1'b0;
      irq_take_q    <= 1'b0;
      wdt_reset_q   <= cpu_run & wdt_ovf;
      if (state_q == pmsw_pkg::ST_WAKE
          && (act_slow_q ? ls_stable : hs_stable)) begin
        if (cause_q == pmsw_pkg::WK_WDT)
          pc_sp_reset_q <= 1'b1;
        else if (cause_q == pmsw_pkg::WK_IRQ)
          irq_take_q <= |(irq_req & ien_q) & ~stack_full;
      end
    end
  end

  assign pc_sp_reset   = pc_sp_reset_q;
  assign irq_take      = irq_take_q;
  assign wdt_reset_req = wdt_reset_q;

  // status flags; a set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pdf_q <= 1'b0;
      to_q  <= 1'b0;
    end else begin
      if (cpu_run && halt_req)
        pdf_q <= 1'b1;
      else if (watchdog_clear_instruction)
        pdf_q <= 1'b0;
      if (wdt_ovf)
        to_q <= 1'b1;
      else if ((cpu_run && halt_req) || watchdog_clear_instruction)
        to_q <= 1'b0;
    end
  end

  // register bus
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go         = aw_have_q & w_have_q;

  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    case (8'(s_axi_araddr) & 8'hfc)
      pmsw_pkg::OFF_SCC: begin
        rd_word[pmsw_pkg::SEL_MSB:pmsw_pkg::SEL_LSB] = sel_q;
        rd_word[pmsw_pkg::FKEEP_BIT] = fkeep_q;
        rd_word[pmsw_pkg::SKEEP_BIT] = skeep_q;
      end
      pmsw_pkg::OFF_HSC: begin
        rd_word[pmsw_pkg::HFLAG_BIT] = hflag_q;
        rd_word[pmsw_pkg::HEN_BIT]   = hen_q;
      end
      pmsw_pkg::OFF_STAT: begin
        rd_word[pmsw_pkg::PDF_BIT] = pdf_q;
        rd_word[pmsw_pkg::TO_BIT]  = to_q;
      end
      pmsw_pkg::OFF_WAKE: rd_word[PORT_W-1:0] = wake_en_q;
      pmsw_pkg::OFF_IEN:  rd_word[IRQ_W-1:0]  = ien_q;
      pmsw_pkg::OFF_MODE: rd_word[4:0] = {act_slow_q, act_div_q, ls_stable};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    case (8'(aw_addr_q) & 8'hfc)
      pmsw_pkg::OFF_SCC, pmsw_pkg::OFF_HSC, pmsw_pkg::OFF_STAT,
      pmsw_pkg::OFF_WAKE, pmsw_pkg::OFF_IEN, pmsw_pkg::OFF_MODE:
        wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= pmsw_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? pmsw_pkg::RESP_OKAY : pmsw_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // software-written control fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q     <= pmsw_pkg::SEL_RESET;
      fkeep_q   <= 1'b0;
      skeep_q   <= 1'b0;
      hen_q     <= pmsw_pkg::HEN_RESET;
      wake_en_q <= pmsw_pkg::WAKE_RESET;
      ien_q     <= pmsw_pkg::IEN_RESET;
    end else if (wr_go && w_strb_q[0]) begin
      case (8'(aw_addr_q) & 8'hfc)
        pmsw_pkg::OFF_SCC: begin
          sel_q   <= w_data_q[pmsw_pkg::SEL_MSB:pmsw_pkg::SEL_LSB];
          fkeep_q <= w_data_q[pmsw_pkg::FKEEP_BIT];
          skeep_q <= w_data_q[pmsw_pkg::SKEEP_BIT];
        end
        pmsw_pkg::OFF_HSC:  hen_q     <= w_data_q[pmsw_pkg::HEN_BIT];
        pmsw_pkg::OFF_WAKE: wake_en_q <= w_data_q[PORT_W-1:0];
        pmsw_pkg::OFF_IEN:  ien_q     <= w_data_q[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= pmsw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? pmsw_pkg::RESP_OKAY : pmsw_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // pmsw_ctrl

// ### verilog/pmsw_pkg.sv
package pmsw_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_SCC  = 8'h00;
  localparam logic [7:0] OFF_HSC  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_WAKE = 8'h0c;
  localparam logic [7:0] OFF_IEN  = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h14;

  // field positions
  localparam int SEL_MSB   = 7;
  localparam int SEL_LSB   = 5;
  localparam int FKEEP_BIT = 1;
  localparam int SKEEP_BIT = 0;
  localparam int HFLAG_BIT = 1;
  localparam int HEN_BIT   = 0;
  localparam int PDF_BIT   = 0;
  localparam int TO_BIT    = 1;

  // values after reset
  localparam logic [2:0] SEL_RESET  = 3'h2;
  localparam logic       HEN_RESET  = 1'b1;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [7:0] IEN_RESET  = 8'h00;

  localparam logic [2:0] SEL_SUB     = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // default watchdog overflow count in sub-clock ticks
  localparam int WDT_LIMIT_DEF = 256;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_STBY = 2'b01,
    ST_WAKE = 2'b10
  } pmsw_state_t;

  // standby mode is {fast_osc_halt_keep, slow_osc_halt_keep}
  typedef enum logic [1:0] {
    SB_SLEEP = 2'b00,
    SB_LOW   = 2'b01,
    SB_FAST  = 2'b10,
    SB_DUAL  = 2'b11
  } pmsw_sb_t;

  typedef enum logic [1:0] {
    WK_NONE = 2'b00,
    WK_PIN  = 2'b01,
    WK_IRQ  = 2'b10,
    WK_WDT  = 2'b11
  } pmsw_cause_t;

  typedef struct packed {
    logic hs_run;
    logic ls_run;
  } pmsw_osc_t;

  typedef struct packed {
    logic sys_tick;
    logic fast_tick;
    logic sub_tick;
  } pmsw_tick_t;

endpackage

// ### bench/pmsw_osc_model.sv
`timescale 1ns/1ns
module pmsw_osc_model (
  input  wire logic                clock,
  input  wire pmsw_pkg::pmsw_osc_t osc_ctl,
  output logic                     low_speed_rc_osc_clk_pin,
  output logic                     low_speed_rc_osc_ready_pin,
  output logic                     high_speed_rc_osc_ready_pin
);
  int lcnt;
  int hcnt;

  initial begin
    low_speed_rc_osc_clk_pin = 1'b0;
    low_speed_rc_osc_ready_pin = 1'b0;
    high_speed_rc_osc_ready_pin = 1'b0;
    lcnt = 0;
    hcnt = 0;
    // odd offset keeps slow edges clear of system clock edges
    #1;
    forever begin
      #14;
      lcnt = osc_ctl.ls_run ? lcnt + 1 : 0;
      low_speed_rc_osc_ready_pin = lcnt > 4;
      if (osc_ctl.ls_run)
        low_speed_rc_osc_clk_pin = ~low_speed_rc_osc_clk_pin;
    end
  end

  // fast oscillator needs restart time before it reports stable
  always @(posedge clock) begin
    hcnt <= osc_ctl.hs_run ? hcnt + 1 : 0;
    high_speed_rc_osc_ready_pin <= osc_ctl.hs_run && hcnt > 8;
  end
endmodule // pmsw_osc_model

// ### bench/pmsw_ctrl_checker.sv
`timescale 1ns/1ns
module pmsw_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_wdata,
  input wire logic [3:0]          s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                halt_req,
  input wire logic                low_speed_rc_osc_ready_pin,
  input wire logic                high_speed_rc_osc_ready_pin,
  input wire pmsw_pkg::pmsw_osc_t osc_ctl,
  input wire logic                cpu_run,
  input wire logic                pc_sp_reset,
  input wire logic                irq_take,
  input wire pmsw_pkg::pmsw_tick_t ticks,
  input wire logic                wdt_reset_req
);
  logic [1:0] kb_q;
  logic       wr_both;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready;

  // keep bits as last written to the clock control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      kb_q <= 2'h0;
    else if (wr_both && s_axi_awaddr == pmsw_pkg::OFF_SCC && s_axi_wstrb[0])
      kb_q <= s_axi_wdata[1:0];
  end

  sequence s_halt;
    cpu_run && halt_req;
  endsequence
  sequence s_resume;
    cpu_run && !$past(cpu_run);
  endsequence

  a_halt_stops_cpu: assert property (s_halt |=> !cpu_run)
    else $error("cpu still runs after halt");
  a_standby_osc: assert property (s_halt |=>
    osc_ctl.hs_run == kb_q[1] && (osc_ctl.ls_run || !kb_q[0]))
    else $error("oscillators wrong for standby mode");
  a_pcsp_on_resume: assert property (pc_sp_reset |-> s_resume)
    else $error("pc reset pulse not at resume");
  a_take_on_resume: assert property (irq_take |-> s_resume)
    else $error("irq response not at resume");
  a_pulse_single: assert property ((pc_sp_reset || irq_take) |=>
    !pc_sp_reset && !irq_take)
    else $error("resume pulse longer than a cycle");
  a_wake_osc_ready: assert property (s_resume |->
    $past(high_speed_rc_osc_ready_pin, 3) || $past(low_speed_rc_osc_ready_pin, 3))
    else $error("resumed before oscillator stable");
  a_bvalid_follows: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_rvalid_follows: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data missing");
  a_busy_refuses: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_tick_only_run: assert property (ticks.sys_tick |-> cpu_run)
    else $error("system tick while cpu stopped");
  a_wdt_req_run: assert property (wdt_reset_req |-> $past(cpu_run))
    else $error("watchdog reset request during standby");
endmodule // pmsw_checker

bind pmsw_ctrl pmsw_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### bench/pmsw_ctrl_tb.sv
`timescale 1ns/1ns
module pmsw_ctrl_tb;
  logic                 clock, rst, halt_req, watchdog_clear_instruction;
  logic                 wdt_enable, stack_full, low_speed_rc_osc_clk_pin, cpu_run;
  logic                 low_speed_rc_osc_ready_pin, high_speed_rc_osc_ready_pin, wdt_reset_req;
  logic                 pc_sp_reset, irq_take, saw_irq, saw_pcsp;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                 s_axi_rready;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic [3:0]           s_axi_wstrb;
  logic [7:0]           s_axi_awaddr, s_axi_araddr, irq_req, port_a_pin;
  logic [31:0]          s_axi_wdata, s_axi_rdata, rd_d;
  pmsw_pkg::pmsw_osc_t  osc_ctl;
  pmsw_pkg::pmsw_tick_t ticks;
  int                   errors, n_tests, cyc;

  pmsw_ctrl #(.WDT_LIMIT(4)) dut (.*);
  pmsw_osc_model osc (.*);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (pc_sp_reset === 1'b1)
      saw_pcsp <= 1'b1;
    if (irq_take === 1'b1)
      saw_irq <= 1'b1;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a > pmsw_pkg::OFF_MODE) ? pmsw_pkg::RESP_SLVERR
                                    : pmsw_pkg::RESP_OKAY;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, resp_of(a)});
    @(posedge clock);
  endtask

  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, resp_of(a)});
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, x,
                    input string nm);
    axr(a);
    chk(nm, rd_d & m, x);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m, x,
                      input string nm);
    int n;
    n = 0;
    do begin
      axr(a);
      n++;
    end while ((rd_d & m) !== x && n < 100);
    chk(nm, rd_d & m, x);
  endtask

  task automatic halt();
    saw_irq = 1'b0;
    saw_pcsp = 1'b0;
    halt_req <= 1'b1;
    @(posedge clock);
    halt_req <= 1'b0;
    @(posedge clock);
    chk("cpu_run", {31'h0, cpu_run}, 32'h0);
  endtask

  task automatic waitrun();
    while (cpu_run !== 1'b1)
      @(posedge clock);
    repeat (2) @(posedge clock);
  endtask

  task automatic clr();
    watchdog_clear_instruction <= 1'b1;
    @(posedge clock);
    watchdog_clear_instruction <= 1'b0;
    @(posedge clock);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {errors, n_tests, cyc} = '0;
    {rst, saw_irq, saw_pcsp} = 3'b100;
    {halt_req, watchdog_clear_instruction, wdt_enable, stack_full} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    irq_req = 8'h00;
    port_a_pin = 8'hff;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(pmsw_pkg::OFF_SCC, 32'hffffffff, 32'h40, "scc reset");
    poll(pmsw_pkg::OFF_HSC, 32'hffffffff, 32'h3, "hsc reset");
    rd(pmsw_pkg::OFF_STAT, 32'hffffffff, 32'h0, "stat reset");
    axw(8'h18, 32'hffffffff);
    rd(8'h18, 32'hffffffff, 32'h0, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 7; k++) begin
      axw(pmsw_pkg::OFF_SCC, 32'he0);
      poll(pmsw_pkg::OFF_MODE, 32'h11, 32'h11, "slow");
      axw(pmsw_pkg::OFF_SCC, 32'(k) << 5);
      poll(pmsw_pkg::OFF_MODE, 32'h1e, 32'(k) << 1, "fast");
    end
    axw(pmsw_pkg::OFF_SCC, 32'he0);
    poll(pmsw_pkg::OFF_MODE, 32'h11, 32'h11, "slow");
    axw(pmsw_pkg::OFF_HSC, 32'h0);
    poll(pmsw_pkg::OFF_HSC, 32'h3, 32'h0, "hs off");
    axw(pmsw_pkg::OFF_HSC, 32'h1);
    rd(pmsw_pkg::OFF_HSC, 32'h2, 32'h0, "hs flag low");
    poll(pmsw_pkg::OFF_HSC, 32'h3, 32'h3, "hs flag high");
    $display("test clock select done");
    axw(pmsw_pkg::OFF_SCC, 32'h01);
    wdt_enable <= 1'b1;
    halt();
    waitrun();
    wdt_enable <= 1'b0;
    rd(pmsw_pkg::OFF_STAT, 32'h3, 32'h3, "wdt wake");
    chk("wdt pulses", {30'h0, saw_irq, saw_pcsp}, 32'h1);
    $display("test watchdog done");
    axw(pmsw_pkg::OFF_WAKE, 32'h01);
    for (int m = 0; m < 4; m++) begin
      axw(pmsw_pkg::OFF_SCC, 32'(m));
      halt();
      rd(pmsw_pkg::OFF_STAT, 32'h3, 32'h1, "entry flags");
      rd(pmsw_pkg::OFF_SCC, 32'hff, 32'(m), "scc kept");
      port_a_pin <= 8'hfe;
      waitrun();
      port_a_pin <= 8'hff;
      rd(pmsw_pkg::OFF_STAT, 32'h3, 32'h1, "pdf stays");
      chk("pin pulses", {30'h0, saw_irq, saw_pcsp}, 32'h0);
      clr();
      rd(pmsw_pkg::OFF_STAT, 32'h3, 32'h0, "pdf cleared");
    end
    $display("test pin wake done");
    axw(pmsw_pkg::OFF_IEN, 32'h03);
    for (int s = 0; s < 2; s++) begin
      irq_req <= 8'h01;
      stack_full <= s[0];
      halt();
      repeat (40) @(posedge clock);
      chk("armed irq", {31'h0, cpu_run}, 32'h0);
      irq_req <= 8'h03;
      waitrun();
      chk("irq take", {31'h0, saw_irq}, 32'(s == 0));
      irq_req <= 8'h00;
      clr();
    end
    $display("test irq wake done");
    stop_test();
  end
endmodule // pmsw_ctrl_tb
